// File: hw/srl_map.svh
// Offsets, field positions and table constants for the read latency lookup.
`ifndef SRL_MAP_SVH
`define SRL_MAP_SVH

// Table geometry.
`define SRL_ROW_LEN 8'h0e
`define SRL_ROW_FIRST 8'h12
`define SRL_ROW_COUNT 3'h5
`define SRL_TABLE_END 8'h58
`define SRL_FAMILY_COUNT 3'h6

// Row start offsets in the window.
`define SRL_OFS_ROW2 8'h12
`define SRL_OFS_ROW3 8'h20
`define SRL_OFS_ROW4 8'h2e
`define SRL_OFS_ROW5 8'h3c
`define SRL_OFS_ROW6 8'h4a
`define SRL_OFS_QIO_MODE_R3 8'h2c
`define SRL_OFS_QIO_LAT_R3 8'h2d

// Field positions inside one row.
`define SRL_FLD_FREQ 8'h00
`define SRL_FLD_CODE 8'h01
`define SRL_FLD_RD_MODE 8'h02
`define SRL_FLD_RD_LAT 8'h03
`define SRL_FLD_FAST_MODE 8'h04
`define SRL_FLD_FAST_LAT 8'h05
`define SRL_FLD_DOUT_MODE 8'h06
`define SRL_FLD_DOUT_LAT 8'h07
`define SRL_FLD_QOUT_MODE 8'h08
`define SRL_FLD_QOUT_LAT 8'h09
`define SRL_FLD_DIO_MODE 8'h0a
`define SRL_FLD_DIO_LAT 8'h0b
`define SRL_FLD_QIO_MODE 8'h0c
`define SRL_FLD_QIO_LAT 8'h0d

// Frequency limit bytes.
`define SRL_FREQ_50 8'h32
`define SRL_FREQ_80 8'h50
`define SRL_FREQ_90 8'h5a
`define SRL_FREQ_104 8'h68
`define SRL_FREQ_133 8'h85

// Latency codes.
`define SRL_CODE_00 2'h0
`define SRL_CODE_01 2'h1
`define SRL_CODE_10 2'h2
`define SRL_CODE_11 2'h3

// Cycle counts.
`define SRL_UNSUP 8'hff
`define SRL_CYC0 8'h00
`define SRL_CYC1 8'h01
`define SRL_CYC2 8'h02
`define SRL_CYC4 8'h04
`define SRL_CYC5 8'h05
`define SRL_CYC8 8'h08

`endif

// File: hw/srl_pkg.sv
// Types shared by the read latency lookup.
package srl_pkg;

    // Read command families in table order.
    typedef enum logic [2:0] {
        SRL_CMD_READ = 3'h0,
        SRL_CMD_FAST = 3'h1,
        SRL_CMD_DOUT = 3'h2,
        SRL_CMD_QOUT = 3'h3,
        SRL_CMD_DIO = 3'h4,
        SRL_CMD_QIO = 3'h5
    } srl_cmd_t;

    // Lookup request: a band row plus a command family.
    typedef struct packed {
        logic [2:0] row;
        srl_cmd_t cmd;
    } srl_req_t;

    // Lookup answer.
    typedef struct packed {
        logic [7:0] freq;
        logic [1:0] code;
        logic [7:0] mode;
        logic [7:0] lat;
        logic unsup;
    } srl_ans_t;

    // Reader states, one-hot.
    typedef enum logic [1:0] {
        SRL_ST_IDLE = 2'b01,
        SRL_ST_ANS = 2'b10
    } srl_state_t;

endpackage : srl_pkg

// File: hw/srl_latency_lookup.sv
// Read-only single-data-rate read latency parameter table with two read ports.
//
// Function
// - All-ones entry means command unsupported in band.
// - Row three: 80 MHz limit, byte 50h, code 00b.
// - 80 MHz quad I/O: 2 mode, 4 latency.
// - Row four: 90 MHz, byte 5Ah, code 01b.
// - Row five: 104 MHz, byte 68h, code 10b.
// - Row six: 133 MHz, byte 85h, code 10b.
// - Plain read unsupported at 90, 104, 133 MHz.
// - Fast read: 0 mode, 8 latency, upper bands.
// - Dual/quad out: 0 mode, 8 latency, 90/104.
// - At 133 MHz dual/quad reads all unsupported.
// - Dual I/O: 4 mode; 0, 1 or 2 latency.
// - Quad I/O: 2 mode; 1, 4 or 5 latency.
`include "srl_map.svh"

module srl_latency_lookup (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_BYTE_REQ,
    input wire logic [7:0] I_BYTE_OFS,
    output logic [7:0] O_BYTE_DATA,
    output logic O_BYTE_VALID,
    input wire logic I_LOOK_REQ,
    input wire srl_pkg::srl_req_t I_LOOK,
    output srl_pkg::srl_ans_t O_LOOK,
    output logic O_LOOK_VALID
);

    // ************************************************************
    // Table contents
    // ************************************************************

    // The byte view is kept as stored bytes, one entry per offset, so a host that walks
    // the offsets sees the image exactly as laid down here. Each row is fourteen bytes:
    // a frequency limit, a latency code, then a mode and a latency byte per command.
    // An all-ones pair marks a command that must not be issued in that band.
    // The decoded port keeps its own field logic, so both views must be kept in step.
    logic [7:0] tbl_mem [`SRL_ROW_FIRST:`SRL_TABLE_END - 8'h01];

    // Fixed contents; every entry is written so no latch can be inferred.
    always_comb begin
        // 50 MHz band, code 11b: every command runs with the fewest cycles.
        // Only this band still accepts the plain read.
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_FREQ] = `SRL_FREQ_50;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_CODE] = {6'h00, `SRL_CODE_11};
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_RD_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_RD_LAT] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_FAST_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_FAST_LAT] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_DOUT_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_DOUT_LAT] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_QOUT_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_QOUT_LAT] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_DIO_MODE] = `SRL_CYC4;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_DIO_LAT] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_QIO_MODE] = `SRL_CYC2;
        tbl_mem[`SRL_OFS_ROW2 + `SRL_FLD_QIO_LAT] = `SRL_CYC1;

        // 80 MHz band, code 00b: the plain read drops out here.
        // Single and multi output reads need eight latency cycles.
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_FREQ] = `SRL_FREQ_80;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_CODE] = {6'h00, `SRL_CODE_00};
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_RD_MODE] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_RD_LAT] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_FAST_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_FAST_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_DOUT_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_DOUT_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_QOUT_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_QOUT_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_DIO_MODE] = `SRL_CYC4;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_DIO_LAT] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_QIO_MODE] = `SRL_CYC2;
        tbl_mem[`SRL_OFS_ROW3 + `SRL_FLD_QIO_LAT] = `SRL_CYC4;

        // 90 MHz band, code 01b: the dual I/O read gains a latency cycle.
        // Dual I/O needs one, quad I/O four.
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_FREQ] = `SRL_FREQ_90;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_CODE] = {6'h00, `SRL_CODE_01};
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_RD_MODE] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_RD_LAT] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_FAST_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_FAST_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_DOUT_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_DOUT_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_QOUT_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_QOUT_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_DIO_MODE] = `SRL_CYC4;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_DIO_LAT] = `SRL_CYC1;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_QIO_MODE] = `SRL_CYC2;
        tbl_mem[`SRL_OFS_ROW4 + `SRL_FLD_QIO_LAT] = `SRL_CYC4;

        // 104 MHz band, code 10b: one more latency cycle for both I/O reads.
        // This is the fastest band in which the multi-line reads still run.
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_FREQ] = `SRL_FREQ_104;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_CODE] = {6'h00, `SRL_CODE_10};
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_RD_MODE] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_RD_LAT] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_FAST_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_FAST_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_DOUT_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_DOUT_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_QOUT_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_QOUT_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_DIO_MODE] = `SRL_CYC4;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_DIO_LAT] = `SRL_CYC2;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_QIO_MODE] = `SRL_CYC2;
        tbl_mem[`SRL_OFS_ROW5 + `SRL_FLD_QIO_LAT] = `SRL_CYC5;

        // 133 MHz band, code 10b: only the fast read is left.
        // Every other command carries an all-ones pair.
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_FREQ] = `SRL_FREQ_133;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_CODE] = {6'h00, `SRL_CODE_10};
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_RD_MODE] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_RD_LAT] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_FAST_MODE] = `SRL_CYC0;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_FAST_LAT] = `SRL_CYC8;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_DOUT_MODE] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_DOUT_LAT] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_QOUT_MODE] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_QOUT_LAT] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_DIO_MODE] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_DIO_LAT] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_QIO_MODE] = `SRL_UNSUP;
        tbl_mem[`SRL_OFS_ROW6 + `SRL_FLD_QIO_LAT] = `SRL_UNSUP;
    end

    // ************************************************************
    // Decoded field logic
    // ************************************************************

    // One field of one row: row index 0 is the 50 MHz band, 4 the 133 MHz band.
    // Field codes past the last command fall to the default and read as zero.
    function automatic logic [7:0] row_field(input logic [7:0] row, input logic [7:0] fld);
        logic [7:0] res;
        res = `SRL_CYC0;
        case (fld)
            // Frequency limit byte of the band.
            8'h00: begin
                case (row)
                    8'h00: res = `SRL_FREQ_50;
                    8'h01: res = `SRL_FREQ_80;
                    8'h02: res = `SRL_FREQ_90;
                    8'h03: res = `SRL_FREQ_104;
                    default: res = `SRL_FREQ_133;
                endcase
            end
            // Latency code, zero-extended to a byte.
            8'h01: begin
                case (row)
                    8'h00: res = {6'h00, `SRL_CODE_11};
                    8'h01: res = {6'h00, `SRL_CODE_00};
                    8'h02: res = {6'h00, `SRL_CODE_01};
                    default: res = {6'h00, `SRL_CODE_10};
                endcase
            end
            // Plain read: only the slowest band supports it.
            8'h02, 8'h03: res = (row == 8'h00) ? `SRL_CYC0 : `SRL_UNSUP;
            // Fast read mode then latency.
            8'h04: res = `SRL_CYC0;
            8'h05: res = (row == 8'h00) ? `SRL_CYC0 : `SRL_CYC8;
            // Dual and quad output reads.
            8'h06, 8'h08: begin
                res = (row == 8'h04) ? `SRL_UNSUP : `SRL_CYC0;
            end
            8'h07, 8'h09: begin
                case (row)
                    8'h00: res = `SRL_CYC0;
                    8'h04: res = `SRL_UNSUP;
                    default: res = `SRL_CYC8;
                endcase
            end
            // Dual I/O read.
            8'h0a: res = (row == 8'h04) ? `SRL_UNSUP : `SRL_CYC4;
            8'h0b: begin
                case (row)
                    8'h00, 8'h01: res = `SRL_CYC0;
                    8'h02: res = `SRL_CYC1;
                    8'h03: res = `SRL_CYC2;
                    default: res = `SRL_UNSUP;
                endcase
            end
            // Quad I/O read.
            8'h0c: res = (row == 8'h04) ? `SRL_UNSUP : `SRL_CYC2;
            8'h0d: begin
                case (row)
                    8'h00: res = `SRL_CYC1;
                    8'h01: res = `SRL_CYC4;
                    8'h02: res = `SRL_CYC4;
                    8'h03: res = `SRL_CYC5;
                    default: res = `SRL_UNSUP;
                endcase
            end
            default: res = `SRL_CYC0;
        endcase
        return res;
    endfunction : row_field

    // ************************************************************
    // Byte read port
    // ************************************************************

    logic [7:0] byte_data_r;
    logic [7:0] byte_data_nxt;
    logic byte_valid_r;
    logic byte_valid_nxt;
    logic byte_in_range;

    // Offsets outside the table read as zero, so a host scanning past the end sees no junk.
    assign byte_in_range = (I_BYTE_OFS >= `SRL_ROW_FIRST) && (I_BYTE_OFS < `SRL_TABLE_END);

    // Each request answers one cycle later; the data holds until the next request.
    always_comb begin
        byte_data_nxt = byte_data_r;
        byte_valid_nxt = I_BYTE_REQ;
        if (I_BYTE_REQ) begin
            byte_data_nxt = `SRL_CYC0;
            if (byte_in_range) begin
                byte_data_nxt = tbl_mem[I_BYTE_OFS];
            end
        end
    end

    // Registers only; reset clears the answer so no stale byte shows after it.
    // The valid flag is never held, so a host sees exactly one valid cycle per request; back to back requests keep it high.
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            byte_data_r <= 8'h00;
            byte_valid_r <= 1'b0;
        end else begin
            byte_data_r <= byte_data_nxt;
            byte_valid_r <= byte_valid_nxt;
        end
    end

    // Both outputs come straight from flip-flops.
    assign O_BYTE_DATA = byte_data_r;
    assign O_BYTE_VALID = byte_valid_r;

    // ************************************************************
    // Decoded lookup port
    // ************************************************************

    // Decoded port state and the fields picked for the current request.
    srl_pkg::srl_state_t state_r;
    srl_pkg::srl_state_t state_nxt;
    srl_pkg::srl_ans_t ans_r;
    srl_pkg::srl_ans_t ans_nxt;
    logic [7:0] row_sel;
    logic [7:0] mode_fld;
    logic [7:0] code_fld;

    // Rows beyond the last band clamp to the fastest band rather than read garbage.
    assign row_sel = (I_LOOK.row < `SRL_ROW_COUNT) ? {5'h00, I_LOOK.row}
                                                   : {5'h00, `SRL_ROW_COUNT - 3'h1};
    // Each command owns two adjacent fields, mode first, so its mode field sits at
    // twice the command code past the plain read's mode field.
    assign mode_fld = `SRL_FLD_RD_MODE + {4'h0, I_LOOK.cmd, 1'b0};
    // The code byte is fetched whole; only its low two bits carry the latency code.
    assign code_fld = row_field(row_sel, `SRL_FLD_CODE);

    // A lookup is taken in idle or in the answer state, so requests may run back to back.
    always_comb begin
        state_nxt = state_r;
        ans_nxt = ans_r;
        case (state_r)
            srl_pkg::SRL_ST_IDLE, srl_pkg::SRL_ST_ANS: begin
                if (I_LOOK_REQ) begin
                    ans_nxt.freq = row_field(row_sel, `SRL_FLD_FREQ);
                    ans_nxt.code = code_fld[1:0];
                    ans_nxt.mode = row_field(row_sel, mode_fld);
                    ans_nxt.lat = row_field(row_sel, mode_fld + 8'h01);
                    ans_nxt.unsup = (ans_nxt.mode == `SRL_UNSUP)
                                  || (ans_nxt.lat == `SRL_UNSUP);
                    state_nxt = srl_pkg::SRL_ST_ANS;
                end else begin
                    state_nxt = srl_pkg::SRL_ST_IDLE;
                end
            end
            default: state_nxt = srl_pkg::SRL_ST_IDLE;
        endcase
    end

    // Registers only; the answer holds until the next request is taken.
    // Reset clears it so the first answer after reset is always fresh.
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_r <= srl_pkg::SRL_ST_IDLE;
            ans_r <= '0;
        end else begin
            state_r <= state_nxt;
            ans_r <= ans_nxt;
        end
    end

    // The answer is registered; valid follows the one-hot answer state.
    assign O_LOOK = ans_r;
    assign O_LOOK_VALID = (state_r == srl_pkg::SRL_ST_ANS);

endmodule : srl_latency_lookup

// File: sim/srl_lookup_asserts.sv
// Port checks for the read latency lookup.
module srl_lookup_asserts (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_BYTE_REQ,
    input wire logic [7:0] I_BYTE_OFS,
    input wire logic [7:0] O_BYTE_DATA,
    input wire logic O_BYTE_VALID,
    input wire logic I_LOOK_REQ,
    input wire srl_pkg::srl_req_t I_LOOK,
    input wire srl_pkg::srl_ans_t O_LOOK,
    input wire logic O_LOOK_VALID
);
    // All checks sample on the rising edge and stand down in reset.
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // Band qualifiers; rows past the top clamp to the top band.
    wire logic top = I_LOOK_REQ && I_LOOK.row >= 3'h4;
    wire logic mid = I_LOOK_REQ && I_LOOK.row >= 3'h2;
    a_qio_mode80: assert property (I_BYTE_REQ && I_BYTE_OFS == 8'h2c |=>
        O_BYTE_VALID && O_BYTE_DATA == 8'h02) else $error("quad io mode byte wrong");
    a_row4_start: assert property (I_BYTE_REQ && I_BYTE_OFS == 8'h2e |=>
        O_BYTE_VALID && O_BYTE_DATA == 8'h5a) else $error("row four limit wrong");
    a_unsup_flag: assert property (O_LOOK_VALID |->
        O_LOOK.unsup == (O_LOOK.mode == 8'hff || O_LOOK.lat == 8'hff)) else $error("unsup flag");
    a_band_104: assert property (I_LOOK_REQ && I_LOOK.row == 3'h3 |=>
        O_LOOK_VALID && O_LOOK.freq == 8'h68 && O_LOOK.code == 2'h2) else $error("band 104");
    a_band_133: assert property (top |=>
        O_LOOK_VALID && O_LOOK.freq == 8'h85 && O_LOOK.code == 2'h2) else $error("band 133");
    a_plain_gone: assert property (mid && I_LOOK.cmd == srl_pkg::SRL_CMD_READ |=>
        O_LOOK.unsup && O_LOOK.mode == 8'hff && O_LOOK.lat == 8'hff) else $error("plain read");
    a_fast_eight: assert property (mid && I_LOOK.cmd == srl_pkg::SRL_CMD_FAST |=>
        !O_LOOK.unsup && O_LOOK.mode == 8'h00 && O_LOOK.lat == 8'h08) else $error("fast read");
    a_top_unsup: assert property (top && I_LOOK.cmd >= srl_pkg::SRL_CMD_DOUT |=>
        O_LOOK.unsup || $past(I_LOOK.cmd) > srl_pkg::SRL_CMD_QIO) else $error("top band multi");
    a_dio_lat: assert property (mid && !top && I_LOOK.cmd == srl_pkg::SRL_CMD_DIO |=>
        O_LOOK.mode == 8'h04 && O_LOOK.lat == ($past(I_LOOK.row) == 3'h2 ? 8'h01 : 8'h02))
        else $error("dual io cycles");
    c_top: cover property (top);
    c_unsup: cover property (O_LOOK_VALID && O_LOOK.unsup);
    c_burst: cover property (I_BYTE_REQ ##1 I_BYTE_REQ);
endmodule : srl_lookup_asserts

bind srl_latency_lookup srl_lookup_asserts u_chk (.*);

// File: sim/srl_host_model.sv
// Model of the SPI host controller that reads the latency table.
module srl_host_model (
    input wire logic i_clk,
    output logic o_byte_req,
    output logic [7:0] o_byte_ofs,
    output logic o_look_req,
    output srl_pkg::srl_req_t o_look
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet bus at time zero.
    initial begin
        o_byte_req = 1'b0;
        o_byte_ofs = 8'h00;
        o_look_req = 1'b0;
        o_look = '0;
    end
    // One request per call; a run of calls keeps the strobe high back to back.
    task automatic byte_rd(input logic [7:0] ofs);
        o_byte_req = 1'b1;
        o_byte_ofs = ofs;
        @(negedge i_clk);
    endtask : byte_rd
    task automatic look(input logic [2:0] row, input logic [2:0] cmd);
        o_look_req = 1'b1;
        o_look = srl_pkg::srl_req_t'({row, cmd});
        @(negedge i_clk);
    endtask : look
    // Idle lines are scrambled so a stale request can never pass as fresh.
    task automatic idle();
        o_byte_req = 1'b0;
        o_look_req = 1'b0;
        o_byte_ofs = ~o_byte_ofs;
        o_look = srl_pkg::srl_req_t'(~o_look);
    endtask : idle
    // The slowest band from 80 MHz up that covers the clock keeps the dummy cycles lowest.
    function automatic logic [2:0] band_for(input int mhz);
        return mhz <= 80 ? 3'h1 : mhz <= 90 ? 3'h2 : mhz <= 104 ? 3'h3 : 3'h4;
    endfunction : band_for
endmodule : srl_host_model

// File: sim/srl_latency_lookup_tb.sv
// Self-checking testbench for the read latency lookup.
module srl_latency_lookup_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic byte_req, byte_valid, look_req, look_valid;
    logic [7:0] byte_ofs, byte_data;
    srl_pkg::srl_req_t look;
    srl_pkg::srl_ans_t ans;
    int miscompares = 0;
    int tests_run = 0;
    // Free-running 125 MHz clock.
    initial forever #4 clk = ~clk;
    srl_latency_lookup uut (.I_CLK(clk), .I_RST(rst), .I_BYTE_REQ(byte_req),
        .I_BYTE_OFS(byte_ofs), .O_BYTE_DATA(byte_data), .O_BYTE_VALID(byte_valid),
        .I_LOOK_REQ(look_req), .I_LOOK(look), .O_LOOK(ans), .O_LOOK_VALID(look_valid));
    srl_host_model host (.i_clk(clk), .o_byte_req(byte_req), .o_byte_ofs(byte_ofs),
        .o_look_req(look_req), .o_look(look));
    // Expected limit byte and latency code of a band row.
    function automatic logic [9:0] exp_fc(input logic [2:0] r);
        return r == 3'h1 ? 10'h140 : r == 3'h2 ? 10'h169 : r == 3'h3 ? 10'h1a2 : 10'h216;
    endfunction : exp_fc
    // Expected mode and latency pair; rows past the top clamp to it.
    function automatic logic [15:0] exp_ml(input logic [2:0] r, input logic [2:0] c);
        if (r >= 3'h4) return c == 3'h1 ? 16'h0008 : 16'hffff;
        if (c == 3'h0) return 16'hffff;
        if (c == 3'h4) return {8'h04, r == 3'h3 ? 8'h02 : {7'h00, r == 3'h2}};
        if (c == 3'h5) return {8'h02, r == 3'h3 ? 8'h05 : 8'h04};
        return 16'h0008;
    endfunction : exp_ml
    task automatic chk(input string n, input logic [27:0] e, input logic [27:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Upper rows back to back, then two offsets past the end of the table.
    task automatic t_bytes();
        logic [7:0] p, e;
        logic [9:0] fc;
        logic [15:0] ml;
        for (logic [7:0] o = 8'h2c; o != 8'h5a; o++) begin
            host.byte_rd(o);
            p = (o - 8'h2e) % 8'h0e;
            fc = exp_fc(3'((o - 8'h2e) / 8'h0e + 8'h02));
            ml = o < 8'h2e ? 16'h0204 : exp_ml(3'((o - 8'h2e) / 8'h0e + 8'h02), 3'(p / 2 - 1));
            e = o[0] ? ml[7:0] : ml[15:8];
            if (o >= 8'h2e && p < 8'h02) e = p[0] ? {6'h00, fc[1:0]} : fc[9:2];
            if (o > 8'h57) e = 8'h00;
            chk("byte", {19'h0, 1'b1, e}, {19'h0, byte_valid, byte_data});
        end
        host.idle();
        @(negedge clk);
        $display("test bytes done");
    endtask : t_bytes
    // Every band from 80 MHz up and every command back to back, then a band chosen from a host clock.
    task automatic t_look();
        logic [15:0] ml;
        for (int r = 1; r <= 5; r++) begin
            for (int c = 0; c <= 5; c++) begin
                host.look(3'(r), 3'(c));
                ml = exp_ml(3'(r), 3'(c));
                chk("look", {1'b1, exp_fc(3'(r)), ml, &ml[15:8] | &ml[7:0]}, {look_valid, ans});
            end
        end
        host.look(host.band_for(100), 3'h5);
        chk("band", {1'b1, 27'h1a2_0205 << 1}, {look_valid, ans});
        host.idle();
        @(negedge clk);
        chk("hold", {1'b0, 27'h1a2_0205 << 1}, {look_valid, ans});
        $display("test look done");
    endtask : t_look
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Reset for 16 cycles, one settling cycle, then the scenarios.
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_bytes();
        t_look();
        end_of_test();
    end
endmodule : srl_latency_lookup_tb
